// file: include/rdp_pkg.sv
package rdp_pkg;
   localparam int RDP_ADDR_W = 8;
   localparam logic [7:0] RDP_OFF_CTRL = 8'h00;
   localparam logic [7:0] RDP_OFF_CLOCK = 8'h04;
   localparam logic [7:0] RDP_OFF_WORD_A = 8'h08;
   localparam logic [7:0] RDP_OFF_WORD_B = 8'h0C;
   localparam logic [7:0] RDP_OFF_DEV = 8'h10;
   localparam logic [7:0] RDP_OFF_STATUS = 8'h14;
   localparam int RDP_CTRL_FMT_LSB = 0;
   localparam int RDP_CTRL_SPLIT_BIT = 2;
   localparam int RDP_CTRL_TX_BIT = 3;
   localparam int RDP_CTRL_WSEL_BIT = 4;
   localparam int RDP_CTRL_BAND_BIT = 5;
   localparam int RDP_CTRL_GATE_CS_BIT = 6;
   localparam int RDP_CTRL_GATE_LOCK_BIT = 7;
   localparam int RDP_CLK_REF_LSB = 0;
   localparam int RDP_CLK_PRE1_LSB = 4;
   localparam int RDP_CLK_PRE2_LSB = 8;
   localparam int RDP_DEV_MANT_LSB = 0;
   localparam int RDP_DEV_EXP_LSB = 4;
   localparam int RDP_DEV_SHAPE_BIT = 7;
   localparam int RDP_WORD_SPUR_SPREAD_ENABLE_BIT = 0;
   localparam logic [7:0] RDP_CTRL_RST = 8'h00;
   localparam logic [9:0] RDP_CLOCK_RST = 10'h001;
   localparam logic [23:0] RDP_WORD_RST = 24'h000000;
   localparam logic [7:0] RDP_DEV_RST = 8'h00;
   localparam logic [2:0] RDP_REF_MIN = 3'h1;
   // Symbol period that matches the clock register reset value
   localparam logic [15:0] RDP_PERIOD_RST = 16'h0028;
   // Base divide of 8 expressed in half-cycle units of the first prescaler
   localparam int RDP_SYM_BASE_HALF = 4;
   localparam logic [1:0] RDP_RESP_OKAY = 2'h0;
   localparam logic [1:0] RDP_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      RDP_FMT_SYNC_PLAIN = 2'h0,
      RDP_FMT_SYNC_MANCH = 2'h1,
      RDP_FMT_ASYNC_LO = 2'h2,
      RDP_FMT_ASYNC_HI = 2'h3
   } rdp_fmt_t;

   typedef enum logic [1:0] {
      RDP_BUS_IDLE = 2'h1,
      RDP_BUS_RESP = 2'h2
   } rdp_bus_t;

   // First prescaler factor times two
   function automatic logic [7:0] rdp_pre1_half(input logic [2:0] sel);
      case (sel)
         3'h0: rdp_pre1_half = 8'h05;
         3'h1: rdp_pre1_half = 8'h06;
         3'h2: rdp_pre1_half = 8'h08;
         3'h3: rdp_pre1_half = 8'h0F;
         3'h4: rdp_pre1_half = 8'h19;
         3'h5: rdp_pre1_half = 8'h50;
         3'h6: rdp_pre1_half = 8'h60;
         default: rdp_pre1_half = 8'h80;
      endcase
   endfunction

   function automatic logic [3:0] rdp_pre2(input logic [1:0] sel);
      rdp_pre2 = 4'h1 << sel;
   endfunction
endpackage

// file: logic/rdp_top.sv
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rdp_top
   import rdp_pkg::*;
(
   input wire logic aclk, // System clock, stands in for the crystal
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [rdp_pkg::RDP_ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [rdp_pkg::RDP_ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic bit_clock_pin, // Data clock pin
   input wire logic bidir_bit_pin_i, // Data pin level seen
   output logic bidir_bit_pin_o, // Data pin drive value
   output logic bidir_bit_pin_oe, // Data pin drive enable
   output logic lock_pin, // Lock status pin, low when locked; carries receive data when sync_mode and split are both set
   input wire logic pll_lock, // Synthesizer lock, high when locked
   input wire logic carrier_sense, // Carrier sense, high on carrier
   input wire logic demod_raw, // Raw demodulator decision
   output logic mod_data, // Symbol to the modulator
   output logic mod_ook, // On-off keying selected
   output logic mod_shaping, // Gaussian shaping enabled
   output logic [22:0] synth_word, // Active channel word without spur_spread_enable bit
   output logic synth_spur_spread, // Spur_spread_enable of the active word
   output logic synth_high_band, // Band select to the synthesizer
   output logic [2:0] synth_ref_div, // Reference divider value
   output logic [3:0] dev_mantissa, // Deviation mantissa
   output logic [2:0] dev_exponent // Deviation exponent
);
   import rdp_pkg::*;

   logic [7:0] ctrl_r;
   logic [9:0] clock_r;
   logic [23:0] word_a_r;
   logic [23:0] word_b_r;
   logic [7:0] dev_r;
   rdp_bus_t wst_r;
   rdp_bus_t rst_r;
   logic aw_got_r;
   logic w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [31:0] rd_nxt;
   logic rd_hit;
   logic wr_hit;

   rdp_fmt_t fmt;
   logic split;
   logic tx_mode;
   logic sync_mode;
   logic manch;
   assign fmt = rdp_fmt_t'(ctrl_r[RDP_CTRL_FMT_LSB +: 2]);
   assign split = ctrl_r[RDP_CTRL_SPLIT_BIT];
   assign tx_mode = ctrl_r[RDP_CTRL_TX_BIT];
   assign sync_mode = (fmt == RDP_FMT_SYNC_PLAIN) || (fmt == RDP_FMT_SYNC_MANCH);
   assign manch = (fmt == RDP_FMT_SYNC_MANCH);

   // Pin and analog inputs: two flip-flops, then a third stage on the demodulator input for edge finding
   logic [1:0] tx_sy_r;
   logic [1:0] lock_sy_r;
   logic [1:0] cs_sy_r;
   logic [1:0] dem_sy_r;
   logic dem_d_r;
   logic tx_s;
   logic lock_s;
   logic cs_s;
   logic dem_s;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_sy_r <= 2'h0;
         lock_sy_r <= 2'h0;
         cs_sy_r <= 2'h0;
         dem_sy_r <= 2'h0;
         dem_d_r <= 1'b0;
      end else begin
         tx_sy_r <= {tx_sy_r[0], bidir_bit_pin_i};
         lock_sy_r <= {lock_sy_r[0], pll_lock};
         cs_sy_r <= {cs_sy_r[0], carrier_sense};
         dem_sy_r <= {dem_sy_r[0], demod_raw};
         dem_d_r <= dem_sy_r[1];
      end
   end
   assign tx_s = tx_sy_r[1];
   assign lock_s = lock_sy_r[1];
   assign cs_s = cs_sy_r[1];
   assign dem_s = dem_sy_r[1];

   // AXI4-Lite write side: address and data taken in either order
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            old[8*i +: 8] = nw[8*i +: 8];
         end
      end
      merge = old;
   endfunction

   logic [31:0] m_ctrl;
   logic [31:0] m_clock;
   logic [31:0] m_dev;
   assign m_ctrl = merge({24'h000000, ctrl_r}, wdata_r, wstrb_r);
   assign m_clock = merge({22'h000000, clock_r}, wdata_r, wstrb_r);
   assign m_dev = merge({24'h000000, dev_r}, wdata_r, wstrb_r);
   logic [31:0] m_word_a;
   logic [31:0] m_word_b;
   assign m_word_a = merge({8'h00, word_a_r}, wdata_r, wstrb_r);
   assign m_word_b = merge({8'h00, word_b_r}, wdata_r, wstrb_r);
   assign wr_hit = (awaddr_r == RDP_OFF_CTRL) || (awaddr_r == RDP_OFF_CLOCK) || (awaddr_r == RDP_OFF_WORD_A)
      || (awaddr_r == RDP_OFF_WORD_B) || (awaddr_r == RDP_OFF_DEV);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_r <= RDP_BUS_IDLE;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RDP_RESP_OKAY;
      end else begin
         case (wst_r)
            RDP_BUS_IDLE: begin
               s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready);
               s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready);
               if (s_axi_awvalid && s_axi_awready) begin
                  aw_got_r <= 1'b1;
                  awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  w_got_r <= 1'b1;
                  wdata_r <= s_axi_wdata;
                  wstrb_r <= s_axi_wstrb;
               end
               if (aw_got_r && w_got_r) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? RDP_RESP_OKAY : RDP_RESP_SLVERR;
                  wst_r <= RDP_BUS_RESP;
               end
            end
            RDP_BUS_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  aw_got_r <= 1'b0;
                  w_got_r <= 1'b0;
                  wst_r <= RDP_BUS_IDLE;
               end
            end
            default: wst_r <= RDP_BUS_IDLE;
         endcase
      end
   end

   logic wr_do;
   assign wr_do = (wst_r == RDP_BUS_IDLE) && aw_got_r && w_got_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= RDP_CTRL_RST;
         clock_r <= RDP_CLOCK_RST;
         word_a_r <= RDP_WORD_RST;
         word_b_r <= RDP_WORD_RST;
         dev_r <= RDP_DEV_RST;
      end else if (wr_do) begin
         case (awaddr_r)
            RDP_OFF_CTRL: ctrl_r <= m_ctrl[7:0];
            RDP_OFF_CLOCK: begin
               clock_r <= m_clock[9:0];
               // A divider value of zero is outside the legal range and is raised to one
               if (m_clock[RDP_CLK_REF_LSB +: 3] == 3'h0) begin
                  clock_r[RDP_CLK_REF_LSB +: 3] <= RDP_REF_MIN;
               end
            end
            RDP_OFF_WORD_A: word_a_r <= m_word_a[23:0];
            RDP_OFF_WORD_B: word_b_r <= m_word_b[23:0];
            RDP_OFF_DEV: dev_r <= m_dev[7:0];
            default: ;
         endcase
      end
   end

   // Symbol timing
   logic [15:0] period_r;
   logic [15:0] sym_cnt_r;
   logic [15:0] half_w;
   logic sym_tick;
   logic mid;
   logic edge_seen;
   logic adv;
   logic ret;
   logic half_sel_r;
   logic first_r;
   logic slip;
   logic [2:0] ref_div;
   assign ref_div = clock_r[RDP_CLK_REF_LSB +: 3];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_r <= RDP_PERIOD_RST;
      end else begin
         period_r <= 16'(RDP_SYM_BASE_HALF * (int'(ref_div) + 1)
            * int'(rdp_pre1_half(clock_r[RDP_CLK_PRE1_LSB +: 3]))
            * int'(rdp_pre2(clock_r[RDP_CLK_PRE2_LSB +: 2])));
      end
   end

   assign half_w = period_r >> 1;
   assign sym_tick = sym_cnt_r >= period_r - 16'h0001;
   assign mid = sym_cnt_r == half_w;
   assign edge_seen = dem_s ^ dem_d_r;
   // Received edges nudge the phase by one cycle so the bit clock never glitches
   assign adv = edge_seen && !tx_mode && sync_mode && (sym_cnt_r > half_w) && !sym_tick;
   assign ret = edge_seen && !tx_mode && sync_mode && (sym_cnt_r != 16'h0000) && (sym_cnt_r < half_w);
   assign slip = manch && !tx_mode && mid && half_sel_r && (first_r == dem_s);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sym_cnt_r <= 16'h0000;
      end else if (sym_tick) begin
         sym_cnt_r <= 16'h0000;
      end else if (adv) begin
         sym_cnt_r <= sym_cnt_r + 16'h0002;
      end else if (!ret) begin
         sym_cnt_r <= sym_cnt_r + 16'h0001;
      end
   end

   // Manchester half marker: a user bit spans two symbols
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         half_sel_r <= 1'b0;
      end else if (!manch) begin
         half_sel_r <= 1'b0;
      end else if (sym_tick ^ slip) begin
         half_sel_r <= !half_sel_r;
      end
   end

   // Transmit path
   logic tx_bit_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_bit_r <= 1'b0;
         mod_data <= 1'b0;
      end else if (!tx_mode) begin
         mod_data <= 1'b0;
      end else if (!sync_mode) begin
         mod_data <= tx_s;
      end else if (sym_tick) begin
         if (!manch) begin
            mod_data <= tx_s;
         end else if (half_sel_r) begin
            tx_bit_r <= tx_s;
            mod_data <= tx_s;
         end else begin
            mod_data <= !tx_bit_r;
         end
      end
   end

   // Receive path
   logic rx_bit_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_bit_r <= 1'b0;
         first_r <= 1'b0;
      end else if (mid && !tx_mode) begin
         if (!manch) begin
            rx_bit_r <= dem_s;
         end else if (!half_sel_r) begin
            first_r <= dem_s;
         end else begin
            rx_bit_r <= first_r;
         end
      end
   end

   // Pins
   logic clk_phase;
   logic clk_run;
   assign clk_phase = manch ? !half_sel_r : (sym_cnt_r < half_w);
   assign clk_run = !(ctrl_r[RDP_CTRL_GATE_CS_BIT] && !cs_s) && !(ctrl_r[RDP_CTRL_GATE_LOCK_BIT] && !lock_s);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_clock_pin <= 1'b0;
         bidir_bit_pin_o <= 1'b0;
         bidir_bit_pin_oe <= 1'b0;
         lock_pin <= 1'b1;
      end else begin
         if (sync_mode) begin
            bit_clock_pin <= clk_run && clk_phase;
         end else if (split && !tx_mode) begin
            bit_clock_pin <= dem_s;
         end else begin
            bit_clock_pin <= fmt[0];
         end
         bidir_bit_pin_oe <= !tx_mode && !split;
         bidir_bit_pin_o <= sync_mode ? rx_bit_r : dem_s;
         lock_pin <= (sync_mode && split) ? rx_bit_r : !lock_s;
      end
   end

   // Synthesizer and modulator settings
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         synth_word <= 23'h000000;
         synth_spur_spread <= 1'b0;
         synth_high_band <= 1'b0;
         synth_ref_div <= RDP_REF_MIN;
         dev_mantissa <= 4'h0;
         dev_exponent <= 3'h0;
         mod_ook <= 1'b1;
         mod_shaping <= 1'b0;
      end else begin
         if (ctrl_r[RDP_CTRL_WSEL_BIT]) begin
            synth_word <= word_b_r[23:1];
            synth_spur_spread <= word_b_r[RDP_WORD_SPUR_SPREAD_ENABLE_BIT];
         end else begin
            synth_word <= word_a_r[23:1];
            synth_spur_spread <= word_a_r[RDP_WORD_SPUR_SPREAD_ENABLE_BIT];
         end
         synth_high_band <= ctrl_r[RDP_CTRL_BAND_BIT];
         synth_ref_div <= ref_div;
         dev_mantissa <= dev_r[RDP_DEV_MANT_LSB +: 4];
         dev_exponent <= dev_r[RDP_DEV_EXP_LSB +: 3];
         mod_ook <= dev_r[RDP_DEV_MANT_LSB +: 4] == 4'h0;
         mod_shaping <= dev_r[RDP_DEV_SHAPE_BIT];
      end
   end

   // AXI4-Lite read side
   always_comb begin
      rd_nxt = 32'h00000000;
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'h0})
         RDP_OFF_CTRL: rd_nxt = {24'h000000, ctrl_r};
         RDP_OFF_CLOCK: rd_nxt = {22'h000000, clock_r};
         RDP_OFF_WORD_A: rd_nxt = {8'h00, word_a_r};
         RDP_OFF_WORD_B: rd_nxt = {8'h00, word_b_r};
         RDP_OFF_DEV: rd_nxt = {24'h000000, dev_r};
         RDP_OFF_STATUS: rd_nxt = {24'h000000, 1'b0, half_sel_r, cs_s, lock_s, rx_bit_r, mod_data,
            bit_clock_pin, mod_ook};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_r <= RDP_BUS_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RDP_RESP_OKAY;
      end else begin
         case (rst_r)
            RDP_BUS_IDLE: begin
               s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_nxt;
                  s_axi_rresp <= rd_hit ? RDP_RESP_OKAY : RDP_RESP_SLVERR;
                  rst_r <= RDP_BUS_RESP;
               end
            end
            RDP_BUS_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
                  rst_r <= RDP_BUS_IDLE;
               end
            end
            default: rst_r <= RDP_BUS_IDLE;
         endcase
      end
   end

   // Checks
   AST_OOK: assert property (@(posedge aclk) disable iff (!aresetn)
      (dev_r[3:0] == 4'h0) |=> mod_ook) else $error("ook not selected for zero mantissa");
   AST_WORD_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r[RDP_CTRL_WSEL_BIT] |=> synth_word == $past(word_b_r[23:1])) else $error("word b not used");
   AST_SPUR_SPREAD_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_r[RDP_CTRL_WSEL_BIT] |=> synth_spur_spread == $past(word_a_r[0])) else $error("spur_spread_enable bit wrong");
   AST_ASYNC_STATIC: assert property (@(posedge aclk) disable iff (!aresetn)
      (!sync_mode && !split) |=> bit_clock_pin == $past(ctrl_r[0])) else $error("idle clock level wrong");
   AST_SPLIT_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
      (sync_mode && split) |=> lock_pin == $past(rx_bit_r)) else $error("lock pin not carrying rx data");
   AST_PASS_TX: assert property (@(posedge aclk) disable iff (!aresetn)
      (!sync_mode && tx_mode) |=> mod_data == $past(tx_s)) else $error("transparent tx not passed");
   AST_BIDIR_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
      (aresetn && !split && !tx_mode) |=> bidir_bit_pin_oe) else $error("data pin not driven in receive");
   AST_BIDIR_TX: assert property (@(posedge aclk) disable iff (!aresetn)
      (aresetn && (tx_mode || split)) |=> !bidir_bit_pin_oe) else $error("data pin driven while released");
   AST_MANCH_MID: assert property (@(posedge aclk) disable iff (!aresetn)
      (manch && tx_mode && sym_tick && !half_sel_r && $stable(ctrl_r)) |=> mod_data == !$past(tx_bit_r))
      else $error("manchester second half not inverted");
   AST_REF_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
      synth_ref_div != 3'h0) else $error("reference divider zero");
   AST_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
      ($stable(clock_r) && clock_r == 10'h001) |=> period_r == 16'h0028) else $error("symbol period wrong");
endmodule // rdp_top

// file: bench/rdp_host.sv
`timescale 1ns/1ps
module rdp_host (
   input wire logic aclk, // System clock
   input wire logic bit_clock_pin, // Data clock from the device
   input wire logic bidir_bit_pin_o, // Device drive value
   input wire logic bidir_bit_pin_oe, // Device drive enable
   input wire logic tx_bit, // Bit the host sends next
   input wire logic direct, // Transparent mode, no clock used
   output logic bidir_bit_pin_i, // Resolved data pin level
   output logic rx_bit // Bit taken at the last clock rise
);
   logic clk_q = 1'b0;
   logic host_v = 1'b0;
   always @(posedge aclk) begin
      clk_q <= bit_clock_pin;
      if (direct) begin
         host_v <= tx_bit;
      end else if (clk_q && !bit_clock_pin) begin
         host_v <= tx_bit;
      end
      if (!clk_q && bit_clock_pin) begin
         rx_bit <= bidir_bit_pin_i;
      end
   end
   // Host drives the pin whenever the device lets go
   assign bidir_bit_pin_i = bidir_bit_pin_oe ? bidir_bit_pin_o : host_v;
endmodule // rdp_host

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import rdp_pkg::*;
   localparam logic [1:0] OK = RDP_RESP_OKAY;
   localparam logic [1:0] ER = RDP_RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic pll_lock = 1'b1;
   logic carrier_sense = 1'b1;
   logic demod_raw = 1'b0;
   logic tx_bit = 1'b0;
   logic direct = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic bit_clock_pin, bidir_bit_pin_i, bidir_bit_pin_o, bidir_bit_pin_oe, lock_pin, rx_bit;
   logic mod_data, mod_ook, mod_shaping, synth_spur_spread, synth_high_band;
   logic [22:0] synth_word;
   logic [2:0] synth_ref_div, dev_exponent;
   logic [3:0] dev_mantissa;
   logic [33:0] exp_q[$];
   logic [23:0] wa, wb;
   logic d, b, nb, last, acc;
   int errors = 0;
   int cmp_count = 0;
   int h1[8] = '{5, 6, 8, 15, 25, 80, 96, 128};
   realtime t0;
   rdp_top dut_u (.*);
   rdp_host host_u (.*);
   always #2.5 aclk = ~aclk;
   task automatic cmp(input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (e !== g) begin
         errors++;
         $display("ERROR %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r);
      exp_q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      cyc(2);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r);
      exp_q.push_back({r, dt});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      cyc(1);
   endtask
   // Bus answers are checked against the oldest note
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) cmp(exp_q.pop_front(), {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) cmp(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
   end
   function automatic int per(input int r, input int p1, input int p2);
      return 4 * (r + 1) * h1[p1] * (1 << p2);
   endfunction
   task automatic setc(input int r, input int p1, input int p2);
      wr(RDP_OFF_CLOCK, 32'(r + 16 * p1 + 256 * p2), OK);
   endtask
   // Skips a partial period after reconfiguration
   task automatic meas(input int p);
      repeat (2) @(posedge bit_clock_pin);
      t0 = $realtime;
      @(posedge bit_clock_pin);
      cmp(p, int'(($realtime - t0) / 5.0));
      cyc(1);
   endtask
   task automatic txrun(input int p, input logic man);
      @(posedge bit_clock_pin);
      b = 1'($urandom);
      tx_bit <= b;
      for (int i = 0; i < 6; i++) begin
         @(posedge bit_clock_pin);
         cyc(p / 4);
         cmp({1'b0, b}, {bidir_bit_pin_oe, mod_data});
         nb = b;
         b = 1'($urandom);
         tx_bit <= b;
         if (man) cyc(p / 2);
         if (man) cmp(!nb, mod_data);
      end
   endtask
   task automatic tdone(input string n);
      $display("test %s done", n);
   endtask
   initial begin
      #400000;
      errors++;
      report_and_stop;
   end
   initial begin
      void'($urandom(32'h164F0797));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      cyc(1);
      rd(RDP_OFF_CTRL, 32'h0, OK);
      rd(RDP_OFF_CLOCK, 32'h1, OK);
      rd(RDP_OFF_WORD_B, 32'h0, OK);
      rd(RDP_OFF_DEV, 32'h0, OK);
      rd(8'h20, 32'h0, ER);
      wr(8'h20, 32'hFF, ER);
      wr(RDP_OFF_STATUS, 32'hFF, ER);
      wr(RDP_OFF_CLOCK, 32'h0, OK);
      rd(RDP_OFF_CLOCK, 32'h1, OK);
      tdone("registers");
      wa = 24'($urandom);
      wb = 24'($urandom);
      wr(RDP_OFF_WORD_A, {8'h0, wa}, OK);
      wr(RDP_OFF_WORD_B, {8'h0, wb}, OK);
      wr(RDP_OFF_CTRL, 32'h30, OK);
      cmp({wb, 1'b1}, {synth_word, synth_spur_spread, synth_high_band});
      wr(RDP_OFF_CTRL, 32'h0, OK);
      cmp({wa, 1'b0}, {synth_word, synth_spur_spread, synth_high_band});
      wr(RDP_OFF_DEV, 32'hD0, OK);
      cmp({2'h3, 3'h5, 4'h0}, {mod_ook, mod_shaping, dev_exponent, dev_mantissa});
      wr(RDP_OFF_DEV, 32'h3A, OK);
      cmp({2'h0, 3'h3, 4'hA}, {mod_ook, mod_shaping, dev_exponent, dev_mantissa});
      tdone("carrier");
      for (int i = 0; i < 8; i++) begin
         setc(1, i, 0);
         meas(per(1, i, 0));
      end
      for (int i = 0; i < 4; i++) begin
         setc(1, 0, i);
         meas(per(1, 0, i));
      end
      setc(3, 2, 1);
      cmp(3'h3, synth_ref_div);
      meas(per(3, 2, 1));
      setc(1, 0, 0);
      tdone("rates");
      wr(RDP_OFF_CTRL, 32'h08, OK);
      txrun(40, 1'b0);
      wr(RDP_OFF_CTRL, 32'h09, OK);
      meas(80);
      txrun(80, 1'b1);
      tdone("transmit");
      for (int s = 0; s < 2; s++) begin
         wr(RDP_OFF_CTRL, 32'(4 * s), OK);
         for (int v = 0; v < 2; v++) begin
            demod_raw <= v[0];
            cyc(200);
            if (s == 0) cmp({2'h2, v[0]}, {bidir_bit_pin_oe, lock_pin, rx_bit});
            if (s == 1) cmp(v[0], lock_pin);
         end
      end
      wr(RDP_OFF_CTRL, 32'h01, OK);
      for (int k = 0; k < 96; k++) begin
         demod_raw <= k[0] ^ k[1];
         cyc(40);
         if (k > 63 && k[0]) cmp(!last, rx_bit);
         if (k[0]) last = rx_bit;
      end
      tdone("receive");
      direct <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         wr(RDP_OFF_CTRL, 32'({m[2:1], 1'b1, m[0]}), OK);
         repeat (3) begin
            d = 1'($urandom);
            demod_raw <= d;
            tx_bit <= d;
            cyc(8);
            if (m[2]) cmp({m[0], d}, {bit_clock_pin, mod_data});
            if (m[2:1] == 0) cmp({m[0], d}, {bit_clock_pin, bidir_bit_pin_o});
            if (m[2:1] == 1) cmp(d, bit_clock_pin);
         end
      end
      direct <= 1'b0;
      tdone("transparent");
      for (int g = 0; g < 2; g++) begin
         wr(RDP_OFF_CTRL, g ? 32'h80 : 32'h40, OK);
         carrier_sense <= 1'(g);
         pll_lock <= 1'(!g);
         cyc(10);
         acc = 1'b0;
         repeat (100) begin
            @(posedge aclk);
            acc = acc | bit_clock_pin;
         end
         cmp({1'b0, 1'(g)}, {acc, lock_pin});
         carrier_sense <= 1'b1;
         pll_lock <= 1'b1;
         meas(40);
      end
      tdone("gating");
      report_and_stop;
   end
endmodule // tb_top
